// [rtl/czs_top.sv]
// Purpose: configuration serial slave and delay-zero / shorted-thermistor shutdown control
// Assumes: serial clock and data sampled on core_clk, far slower than 20 MHz
// Notes: register storage is an internal flip-flop array reached only over the serial bus
`timescale 1ns/1ns
module czs_top
    import czs_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic delay_zero_select,
    input wire logic thermistor_short,
    input wire logic charger_detect,
    input wire logic serial_clk_pin,
    input wire logic serial_data_pin_in,
    output logic serial_data_pin_out,
    output logic serial_data_pin_oe,
    output logic use_min_delay,
    output logic shutdown,
    output logic regulator_enable
);
    import czs_pkg::*;

    logic dz_s, ts_s, chg_s, scl_s, sda_s;
    czs_sync u_dz (
        .core_clk(core_clk),
        .rst(rst),
        .async_in(delay_zero_select),
        .sync_out(dz_s)
    );
    czs_sync u_ts (
        .core_clk(core_clk),
        .rst(rst),
        .async_in(thermistor_short),
        .sync_out(ts_s)
    );
    czs_sync u_chg (
        .core_clk(core_clk),
        .rst(rst),
        .async_in(charger_detect),
        .sync_out(chg_s)
    );
    czs_sync u_scl (
        .core_clk(core_clk),
        .rst(rst),
        .async_in(serial_clk_pin),
        .sync_out(scl_s)
    );
    czs_sync u_sda (
        .core_clk(core_clk),
        .rst(rst),
        .async_in(serial_data_pin_in),
        .sync_out(sda_s)
    );

    ////////////////////////////////////////////////////////////////////////////
    // shorted-thermistor timer and shutdown

    logic [TMR_W-1:0] short_tmr, next_short_tmr;
    logic shut, next_shut;
    logic [TMR_W-1:0] short_limit;

    always_comb begin
        // delay-zero picks the minimum qualification time
        if (dz_s) begin
            short_limit = TMR_W'(SHORT_FAST_CYC);
        end else begin
            short_limit = TMR_W'(SHORT_NORMAL_CYC);
        end
        next_short_tmr = short_tmr;
        next_shut = shut;
        if (shut) begin
            next_short_tmr = '0;
            if (chg_s) begin
                next_shut = 1'b0;
            end
        end else if (!ts_s) begin
            next_short_tmr = '0;
        end else if (short_tmr > short_limit) begin
            next_shut = 1'b1;
            next_short_tmr = '0;
        end else begin
            next_short_tmr = short_tmr + TMR_W'(1);
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            short_tmr <= '0;
            shut <= 1'b0;
            use_min_delay <= 1'b0;
            shutdown <= 1'b0;
            regulator_enable <= 1'b0;
        end else begin
            short_tmr <= next_short_tmr;
            shut <= next_shut;
            use_min_delay <= dz_s;
            shutdown <= next_shut;
            regulator_enable <= !next_shut;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // serial slave: sampled line edges, start and stop detection

    logic scl_d, sda_d;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    logic scl_rise, scl_fall, start_cond, stop_cond;
    assign scl_rise = scl_s && !scl_d;
    assign scl_fall = !scl_s && scl_d;
    assign start_cond = scl_s && scl_d && sda_d && !sda_s;
    assign stop_cond = scl_s && scl_d && !sda_d && sda_s;

    function automatic logic addr_match(input logic [7:0] b);
        // general call never matches since own address differs
        return (b[7:1] == SLAVE_ADDR) && (b[7:1] != GENERAL_CALL);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // slave state machine

    czs_state_e state, next_state;
    logic [7:0] shreg, next_shreg;
    logic [2:0] bitn, next_bitn;
    logic [REG_AW-1:0] loc, next_loc;
    logic rd_mode, next_rd_mode;
    logic drv, next_drv;
    logic dout, next_dout;
    logic wr_en;
    logic [REG_DW-1:0] regs [0:(1<<REG_AW)-1];

    function automatic logic shreg_full(input logic [2:0] b);
        return b == 3'h0;
    endfunction

    logic got_bits, next_got_bits;
    logic byte_done;
    assign byte_done = shreg_full(bitn) && got_bits;
    always_comb begin
        next_got_bits = got_bits;
        if (start_cond || (scl_fall && byte_done) || state == CZS_IDLE) begin
            next_got_bits = 1'b0;
        end else if (scl_rise && (state == CZS_ADDR || state == CZS_LOC
                || state == CZS_WDATA)) begin
            next_got_bits = 1'b1;
        end
    end

    always_comb begin
        next_state = state;
        next_shreg = shreg;
        next_bitn = bitn;
        next_loc = loc;
        next_rd_mode = rd_mode;
        next_drv = drv;
        next_dout = dout;
        wr_en = 1'b0;
        if (!dz_s) begin
            next_state = CZS_IDLE;
            next_drv = 1'b0;
        end else if (stop_cond) begin
            next_state = CZS_IDLE;
            next_drv = 1'b0;
        end else if (start_cond) begin
            next_state = CZS_ADDR;
            next_bitn = '0;
            next_drv = 1'b0;
        end else begin
            unique case (state)
                CZS_IDLE: begin
                    next_drv = 1'b0;
                end
                CZS_ADDR, CZS_LOC, CZS_WDATA: begin
                    if (scl_rise) begin
                        next_shreg = {shreg[6:0], sda_s};
                        next_bitn = bitn + 3'h1;
                    end
                    if (scl_fall && byte_done) begin
                        if (state == CZS_ADDR) begin
                            if (addr_match(shreg)) begin
                                next_state = CZS_ADDR_ACK;
                                next_rd_mode = shreg[ADDR_RW_BIT] == RW_READ;
                                next_drv = 1'b1;
                                next_dout = 1'b0;
                            end else begin
                                next_state = CZS_IDLE;
                            end
                        end else if (state == CZS_LOC) begin
                            next_loc = shreg;
                            next_state = CZS_LOC_ACK;
                            next_drv = 1'b1;
                            next_dout = 1'b0;
                        end else begin
                            wr_en = 1'b1;
                            next_state = CZS_WDATA_ACK;
                            next_drv = 1'b1;
                            next_dout = 1'b0;
                        end
                    end
                end
                CZS_ADDR_ACK: begin
                    if (scl_fall) begin
                        next_bitn = '0;
                        if (rd_mode) begin
                            next_state = CZS_RDATA;
                            next_shreg = regs[loc];
                            next_dout = regs[loc][7];
                            next_drv = !regs[loc][7];
                        end else begin
                            next_state = CZS_LOC;
                            next_drv = 1'b0;
                        end
                    end
                end
                CZS_LOC_ACK: begin
                    if (scl_fall) begin
                        next_state = CZS_WDATA;
                        next_bitn = '0;
                        next_drv = 1'b0;
                    end
                end
                CZS_WDATA_ACK: begin
                    if (scl_fall) begin
                        // further bytes refused, pointer stays put
                        next_state = CZS_IDLE;
                        next_drv = 1'b0;
                    end
                end
                CZS_RDATA: begin
                    if (scl_fall) begin
                        if (bitn == BIT_LAST) begin
                            // single byte only; master nack or ack both end it
                            next_state = CZS_IDLE;
                            next_drv = 1'b0;
                        end else begin
                            next_bitn = bitn + 3'h1;
                            next_shreg = {shreg[6:0], 1'b0};
                            next_dout = shreg[6];
                            next_drv = !shreg[6];
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state <= CZS_IDLE;
            shreg <= '0;
            bitn <= '0;
            loc <= LOC_RESET;
            rd_mode <= 1'b0;
            drv <= 1'b0;
            dout <= 1'b1;
            got_bits <= 1'b0;
            serial_data_pin_out <= 1'b0;
            serial_data_pin_oe <= 1'b0;
        end else begin
            state <= next_state;
            shreg <= next_shreg;
            bitn <= next_bitn;
            loc <= next_loc;
            rd_mode <= next_rd_mode;
            drv <= next_drv;
            dout <= next_dout;
            got_bits <= next_got_bits;
            // open drain: only ever pulls low, never touches the clock
            serial_data_pin_out <= 1'b0;
            serial_data_pin_oe <= next_drv;
        end
    end

    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            regs[loc] <= shreg;
        end
    end
endmodule

// [rtl/czs_pkg.sv]
// Purpose: shared constants for the configuration serial slave and delay-zero logic
// Assumes: core_clk at 20 MHz
// Notes: times are kept in their own unit, cycle counts derive from them
package czs_pkg;
    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned SHORT_NORMAL_MS = 8000;
    localparam int unsigned SHORT_FAST_MS = 1000;
    localparam longint unsigned SHORT_NORMAL_CYC = longint'(SHORT_NORMAL_MS) * CLK_HZ / 1000;
    localparam longint unsigned SHORT_FAST_CYC = longint'(SHORT_FAST_MS) * CLK_HZ / 1000;
    localparam int TMR_W = 28;
    localparam logic [6:0] SLAVE_ADDR = 7'h10;
    localparam logic [6:0] GENERAL_CALL = 7'h00;
    localparam int ADDR_RW_BIT = 0;
    localparam logic RW_WRITE = 1'b0;
    localparam logic RW_READ = 1'b1;
    localparam int REG_AW = 8;
    localparam int REG_DW = 8;
    localparam logic [7:0] LOC_RESET = 8'h00;
    localparam logic [2:0] BIT_LAST = 3'h7;
    typedef enum logic [2:0] {
        CZS_IDLE, CZS_ADDR, CZS_ADDR_ACK, CZS_LOC, CZS_LOC_ACK,
        CZS_WDATA, CZS_WDATA_ACK, CZS_RDATA
    } czs_state_e;
endpackage

// [rtl/czs_sync.sv]
// Purpose: two-flop synchroniser for pin inputs
// Assumes: single clock domain
// Notes: first stage read only by second stage
`timescale 1ns/1ns
module czs_sync (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic async_in,
    output logic sync_out
);
    logic stage1;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            stage1 <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule

// [verification/czs_top_props.sv]
// Purpose: port-level checks of the configuration slave and shutdown control
// Assumes: one clock domain, synchronous active-high reset
// Notes: long thermistor counts checked through a helper counter
`timescale 1ns/1ns
module czs_top_props
    import czs_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic delay_zero_select,
    input wire logic thermistor_short,
    input wire logic charger_detect,
    input wire logic serial_clk_pin,
    input wire logic serial_data_pin_in,
    input wire logic serial_data_pin_out,
    input wire logic serial_data_pin_oe,
    input wire logic use_min_delay,
    input wire logic shutdown,
    input wire logic regulator_enable
);
    logic [31:0] short_cnt;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////
    // restarts when the short drops, as the design's own count does
    always_ff @(posedge core_clk) begin
        if (rst || !thermistor_short) begin
            short_cnt <= 32'h0;
        end else if (short_cnt != 32'hFFFFFFFF) begin
            short_cnt <= short_cnt + 32'h1;
        end
    end
    chk_delay_stored: assert property (!delay_zero_select [*5] |-> !use_min_delay)
        else $error("min delay used with delay-zero low");
    chk_delay_min: assert property (delay_zero_select [*5] |-> use_min_delay)
        else $error("min delay not applied with delay-zero high");
    chk_ack_gated: assert property ($rose(serial_data_pin_oe) |-> use_min_delay)
        else $error("data pulled low while serial disabled");
    chk_normal_short: assert property (
        $rose(shutdown) && !use_min_delay |-> short_cnt >= SHORT_NORMAL_CYC)
        else $error("shutdown before normal short time");
    chk_fast_short: assert property ($rose(shutdown) |-> short_cnt >= SHORT_FAST_CYC)
        else $error("shutdown before minimum short time");
    chk_charger_wake: assert property (
        (shutdown && charger_detect) [*4] |-> ##[1:6] !shutdown)
        else $error("shutdown not left after charger");
    chk_reg_off: assert property (shutdown |-> !regulator_enable)
        else $error("regulator on during shutdown");
    chk_open_drain: assert property (!serial_data_pin_out)
        else $error("data driven high");
    chk_ack_hold: assert property ($rose(serial_data_pin_oe) |-> serial_data_pin_oe [*8])
        else $error("acknowledge too short");
    chk_data_stable: assert property ($changed(serial_data_pin_oe) |-> !serial_clk_pin)
        else $error("data changed while clock high");
endmodule
bind czs_top czs_top_props chk_u (.core_clk(core_clk), .rst(rst),
    .delay_zero_select(delay_zero_select), .thermistor_short(thermistor_short),
    .charger_detect(charger_detect), .serial_clk_pin(serial_clk_pin),
    .serial_data_pin_in(serial_data_pin_in), .serial_data_pin_out(serial_data_pin_out),
    .serial_data_pin_oe(serial_data_pin_oe), .use_min_delay(use_min_delay),
    .shutdown(shutdown), .regulator_enable(regulator_enable));

// [verification/czs_master.sv]
// Purpose: two-wire bus master model used to program the slave
// Assumes: half bit of 20 core cycles, well above the slave's minimum
// Notes: data released means high through the pull-up
`timescale 1ns/1ns
module czs_master (
    input wire logic core_clk,
    input wire logic sda_line,
    output logic scl,
    output logic sda
);
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    task automatic hw();
        repeat (20) @(negedge core_clk);
    endtask
    task automatic start();
        sda = 1'b1; scl = 1'b1; hw(); sda = 1'b0; hw(); scl = 1'b0;
    endtask
    task automatic stop();
        sda = 1'b0; hw(); scl = 1'b1; hw(); sda = 1'b1; hw();
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // msb first, ack sampled at the end of the ninth clock high
    task automatic send(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sda = b[i]; hw(); scl = 1'b1; hw(); scl = 1'b0;
        end
        sda = 1'b1; hw(); scl = 1'b1; hw();
        ack = (sda_line === 1'b0);
        scl = 1'b0;
    endtask
    task automatic recv(input logic nack, output logic [7:0] d);
        sda = 1'b1;
        for (int i = 7; i >= 0; i--) begin
            hw(); scl = 1'b1; hw(); d[i] = sda_line; scl = 1'b0;
        end
        sda = nack; hw(); scl = 1'b1; hw(); scl = 1'b0;
    endtask
endmodule

// [verification/config_i2c_slave_with_delay_zero_test.sv]
// Purpose: self-checking bench for the configuration slave
// Assumes: 20 MHz core clock, inputs changed at falling edges
// Notes: full shutdown counts exceed the run, only early firing is probed
`timescale 1ns/1ns
`define CHECK(nm, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; \
    $display("MISMATCH %s exp=%0h got=%0h", nm, e, g); end end
module config_i2c_slave_with_delay_zero_test;
    import czs_pkg::*;
    logic core_clk = 1'b0, rst = 1'b1, dz = 1'b0, ts = 1'b0, chg = 1'b0;
    logic scl, sda_m, out, oe, umd, sd, reg_en, a0, a1, a2, a3;
    logic [7:0] d;
    wire sda_line = sda_m & (oe ? out : 1'b1);
    int num_errors = 0, check_count = 0, cycles = 0;
    czs_master mst_u (.core_clk(core_clk), .sda_line(sda_line), .scl(scl), .sda(sda_m));
    czs_top dut_u (.core_clk(core_clk), .rst(rst), .delay_zero_select(dz),
        .thermistor_short(ts), .charger_detect(chg), .serial_clk_pin(scl),
        .serial_data_pin_in(sda_line), .serial_data_pin_out(out), .serial_data_pin_oe(oe),
        .use_min_delay(umd), .shutdown(sd), .regulator_enable(reg_en));
    initial begin
        forever #25 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 40000) begin
            num_errors++;
            summarize();
        end
    end
    task automatic summarize();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic wr3(input logic [7:0] a, l, v);
        mst_u.start(); mst_u.send(a, a0); mst_u.send(l, a1); mst_u.send(v, a2);
    endtask
    task automatic rd(input logic [7:0] l);
        mst_u.start(); mst_u.send(8'h20, a0); mst_u.send(l, a1); mst_u.stop();
        mst_u.start(); mst_u.send(8'h21, a0); mst_u.recv(1'b1, d); mst_u.stop();
    endtask
    task automatic t_reset();
        `CHECK("regulator_enable", 1'b1, reg_en)
        `CHECK("use_min_delay", 1'b0, umd)
        `CHECK("shutdown", 1'b0, sd)
    endtask
    task automatic t_locked();
        wr3(8'h20, 8'h01, 8'h5A); mst_u.stop();
        `CHECK("ack_dz_low", 3'h0, {a0, a1, a2})
    endtask
    task automatic t_write_read();
        dz = 1'b1;
        repeat (10) @(negedge core_clk);
        `CHECK("use_min_delay", 1'b1, umd)
        wr3(8'h20, 8'h05, 8'hA5); mst_u.stop();
        `CHECK("ack_addr", 1'b1, a0)
        `CHECK("ack_loc_data", 2'h3, {a1, a2})
        mst_u.start(); mst_u.send(8'h21, a0); mst_u.recv(1'b1, d); mst_u.stop();
        `CHECK("ack_read", 1'b1, a0)
        `CHECK("read_same_loc", 8'hA5, d)
    endtask
    task automatic t_other_addr();
        wr3(8'h22, 8'h05, 8'h11); mst_u.stop();
        `CHECK("ack_other", 3'h0, {a0, a1, a2})
        wr3(8'h00, 8'h05, 8'h11); mst_u.stop();
        `CHECK("ack_general", 3'h0, {a0, a1, a2})
        rd(8'h05);
        `CHECK("loc_untouched", 8'hA5, d)
    endtask
    task automatic t_no_incr();
        wr3(8'h20, 8'h06, 8'h3C); mst_u.send(8'h77, a3); mst_u.stop();
        `CHECK("extra_byte_ack", 1'b0, a3)
        rd(8'h06);
        `CHECK("single_write", 8'h3C, d)
        rd(8'h05);
        `CHECK("pointer_only", 8'hA5, d)
    endtask
    task automatic t_thermistor();
        ts = 1'b1;
        repeat (3000) @(negedge core_clk);
        `CHECK("early_shutdown", 1'b0, sd)
        ts = 1'b0; chg = 1'b1;
        repeat (5) @(negedge core_clk);
        chg = 1'b0;
        `CHECK("regulator_on", 1'b1, reg_en)
    endtask
    initial begin
        repeat (10) @(negedge core_clk);
        rst = 1'b0;
        repeat (5) @(negedge core_clk);
        t_reset();
        t_locked();
        t_write_read();
        t_other_addr();
        t_no_incr();
        t_thermistor();
        summarize();
    end
endmodule
